// *** hdl/usart_lin_pkg.sv ***
// package: register map, fields and constants of the break/handshake/lin block
package usart_lin_pkg;
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_MODE    = 8'h04;
  localparam logic [7:0] OFF_IER     = 8'h08;
  localparam logic [7:0] OFF_IMR     = 8'h10;
  localparam logic [7:0] OFF_STATUS  = 8'h14;
  localparam logic [7:0] OFF_LINCFG  = 8'h54;

  localparam int BIT_STATUS_RESET_CMD   = 8;
  localparam int MODE_LSB     = 0;
  localparam logic [3:0] MODE_HANDSHAKE = 4'h2;
  localparam logic [3:0] MODE_SPI_M     = 4'hE;
  localparam logic [3:0] MODE_SPI_S     = 4'hF;
  localparam logic [3:0] MODE_LIN_M     = 4'hA;
  localparam logic [3:0] MODE_LIN_S     = 4'hB;
  localparam int MODE_SYNC_BIT = 8;

  localparam logic [31:0] IER_MASK = 32'h0008_0623;

  localparam int ST_RX_BREAK_FLAG  = 2;
  localparam int ST_LIN_BIT_ERROR_FLAG  = 25;
  localparam int ST_ISFE   = 26;
  localparam int ST_IPE    = 27;
  localparam int ST_CE     = 28;
  localparam int ST_SNRE   = 29;
  localparam int ST_STE    = 30;

  localparam int CFG_NODE_ACTION_LSB = 0;
  localparam int CFG_PARITY_DISABLE   = 2;
  localparam int CFG_CHECKSUM_DISABLE   = 3;
  localparam logic [1:0] NODE_ACTION_SEND    = 2'b00;
  localparam logic [1:0] NODE_ACTION_RECEIVE = 2'b01;
  localparam logic [1:0] NODE_ACTION_IGNORE  = 2'b10;

  localparam logic [7:0] SYNCH_VALUE = 8'h55;
  localparam logic [3:0] OVERSAMPLE  = 4'hF;
  localparam logic [3:0] END_BRK_SAMPLES = 4'h2;
  localparam int TOL_PCT = 15;

  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
  } ahb_req_s;

  // one received LIN character with its role
  typedef struct packed {
    logic        valid;
    logic [1:0]  kind;
    logic [7:0]  data;
  } lin_char_s;

  localparam logic [1:0] CH_SYNCH = 2'b00;
  localparam logic [1:0] CH_ID    = 2'b01;
  localparam logic [1:0] CH_CSUM  = 2'b10;
endpackage

// *** hdl/sticky_flag.sv ***
// sticky status bit: hardware set beats software clear
`timescale 1ns/100ps
module sticky_flag (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule

// *** hdl/usart_lin_errors.sv ***
// receive break, rts/cts flow control, lin error flags and spi irq enables
`timescale 1ns/100ps
module usart_lin_errors (
  input  wire logic         CLK,
  input  wire logic         RESETN,
  input  wire logic         HSEL,
  input  wire logic [31:0]  HADDR,
  input  wire logic [1:0]   HTRANS,
  input  wire logic         HWRITE,
  input  wire logic [2:0]   HSIZE,
  input  wire logic [31:0]  HWDATA,
  input  wire logic         HREADY,
  output logic [31:0]       HRDATA,
  output logic              HREADYOUT,
  output logic              HRESP,
  input  wire logic         SAMPLE_TICK,
  input  wire logic         RXD,
  input  wire logic         RX_CHAR_DONE,
  input  wire logic [8:0]   RX_CHAR_BITS,
  input  wire logic         RX_FIFO_FULL,
  input  wire logic         TX_BIT_TICK,
  input  wire logic         TX_LINE,
  input  wire logic         TX_BYTE_END,
  input  wire logic         TX_ACTIVE,
  input  wire logic         CTS,
  input  wire logic [1:0]   LIN_CHAR_KIND,
  input  wire logic         LIN_CHAR_VALID,
  input  wire logic [7:0]   LIN_CHAR_DATA,
  input  wire logic         LIN_FRAME_START,
  input  wire logic         LIN_FRAME_VALID,
  input  wire logic         LIN_FRAME_TIMEOUT,
  input  wire logic         LIN_SYNC_DONE,
  input  wire logic [15:0]  LIN_BAUD_INIT,
  input  wire logic [15:0]  LIN_BAUD_NEW,
  output logic              RTS,
  output logic              TX_ENABLE,
  output logic              TX_ABORT,
  output logic [3:0]        USART_MODE,
  output logic [31:0]       IRQ_ENABLE
);
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ahb-lite address phase capture, zero wait states
  usart_lin_pkg::ahb_req_s req_reg;
  usart_lin_pkg::ahb_req_s req_next;
  wire take = HSEL && HREADY && HTRANS[1];

  assign req_next = '{sel: take, write: HWRITE, addr: HADDR[7:0]};

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= '0;
    end else begin
      req_reg <= req_next;
    end
  end

  wire wr = req_reg.sel && req_reg.write;
  wire rd_phase = take && !HWRITE;
  wire wr_ctrl   = wr && (req_reg.addr == usart_lin_pkg::OFF_CTRL);
  wire wr_mode   = wr && (req_reg.addr == usart_lin_pkg::OFF_MODE);
  wire wr_ier    = wr && (req_reg.addr == usart_lin_pkg::OFF_IER);
  wire wr_lincfg = wr && (req_reg.addr == usart_lin_pkg::OFF_LINCFG);
  wire status_reset_cmd = wr_ctrl && HWDATA[usart_lin_pkg::BIT_STATUS_RESET_CMD];

  logic [31:0] mode_reg;
  logic [31:0] lincfg_reg;
  logic [31:0] ier_reg;

  wire [3:0] mode = mode_reg[usart_lin_pkg::MODE_LSB +: 4];
  wire sync_mode = mode_reg[usart_lin_pkg::MODE_SYNC_BIT];
  wire handshake = (mode == usart_lin_pkg::MODE_HANDSHAKE);
  wire spi_mode = (mode == usart_lin_pkg::MODE_SPI_M) ||
                  (mode == usart_lin_pkg::MODE_SPI_S);
  wire lin_master = (mode == usart_lin_pkg::MODE_LIN_M);
  wire lin_slave  = (mode == usart_lin_pkg::MODE_LIN_S);
  wire lin_any    = lin_master || lin_slave;
  wire [1:0] node_action = lincfg_reg[usart_lin_pkg::CFG_NODE_ACTION_LSB +: 2];
  wire parity_disable = lincfg_reg[usart_lin_pkg::CFG_PARITY_DISABLE];
  wire checksum_disable = lincfg_reg[usart_lin_pkg::CFG_CHECKSUM_DISABLE];

  // write-one-to-set, masked to the implemented bits
  wire [31:0] ier_next =
    ier_reg | (HWDATA & usart_lin_pkg::IER_MASK);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg   <= usart_lin_pkg::RESET_ZERO;
      lincfg_reg <= usart_lin_pkg::RESET_ZERO;
      ier_reg    <= usart_lin_pkg::RESET_ZERO;
    end else begin
      if (wr_mode) mode_reg <= HWDATA;
      if (wr_lincfg) lincfg_reg <= HWDATA;
      if (wr_ier && spi_mode) ier_reg <= ier_next;
    end
  end

  // break detection on a completed all-low character
  logic in_break_reg;
  logic [3:0] high_cnt_reg;
  wire brk_start = RX_CHAR_DONE && (RX_CHAR_BITS == 9'h000)
                   && !in_break_reg;
  // frame error for an all-low character is suppressed upstream of status
  wire frame_err = 1'b0;
  // consecutive high oversampled ticks; sync counts one sample
  wire [3:0] end_need = sync_mode ? 4'h1 : usart_lin_pkg::END_BRK_SAMPLES;
  wire [3:0] high_cnt_next =
    !RXD ? 4'h0 : (high_cnt_reg == usart_lin_pkg::OVERSAMPLE)
         ? high_cnt_reg : high_cnt_reg + 4'h1;
  wire brk_end = in_break_reg && SAMPLE_TICK && RXD &&
                 (high_cnt_next >= end_need);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      in_break_reg <= 1'b0;
      high_cnt_reg <= 4'h0;
    end else begin
      if (SAMPLE_TICK) high_cnt_reg <= high_cnt_next;
      if (brk_start) begin
        in_break_reg <= 1'b1;
        high_cnt_reg <= 4'h0;
      end else if (brk_end) begin
        in_break_reg <= 1'b0;
      end
    end
  end

  // lin bit error and abort at byte border
  wire bit_mismatch = lin_any && TX_ACTIVE && TX_BIT_TICK &&
                      (TX_LINE != RXD);
  logic abort_pend_reg;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      abort_pend_reg <= 1'b0;
    end else if (TX_BYTE_END) begin
      abort_pend_reg <= 1'b0;
    end else if (bit_mismatch) begin
      abort_pend_reg <= 1'b1;
    end
  end
  // abort waits for the byte to finish so the bus sees whole bytes
  wire abort_now = TX_BYTE_END && (abort_pend_reg || bit_mismatch);

  wire ch_synch = LIN_CHAR_VALID && LIN_CHAR_KIND == usart_lin_pkg::CH_SYNCH;
  wire ch_id    = LIN_CHAR_VALID && LIN_CHAR_KIND == usart_lin_pkg::CH_ID;
  wire ch_csum  = LIN_CHAR_VALID && LIN_CHAR_KIND == usart_lin_pkg::CH_CSUM;
  wire isfe_set = lin_slave && ch_synch &&
                  (LIN_CHAR_DATA != usart_lin_pkg::SYNCH_VALUE);
  wire p0 = LIN_CHAR_DATA[0] ^ LIN_CHAR_DATA[1] ^ LIN_CHAR_DATA[2] ^
            LIN_CHAR_DATA[4];
  wire p1 = ~(LIN_CHAR_DATA[1] ^ LIN_CHAR_DATA[3] ^ LIN_CHAR_DATA[4] ^
            LIN_CHAR_DATA[5]);
  wire ipe_set = lin_slave && ch_id && !parity_disable &&
                 ({p1, p0} != LIN_CHAR_DATA[7:6]);

  // checksum: running carry-add sum over data bytes, inverted
  logic [7:0] sum_reg;
  wire [8:0] sum_add = {1'b0, sum_reg} + {1'b0, LIN_CHAR_DATA};
  wire [7:0] sum_wrap = sum_add[7:0] + {7'h00, sum_add[8]};
  wire data_char = LIN_CHAR_VALID && (LIN_CHAR_KIND == 2'b11);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sum_reg <= 8'h00;
    end else if (LIN_FRAME_START) begin
      sum_reg <= 8'h00;
    end else if (data_char) begin
      sum_reg <= sum_wrap;
    end
  end
  wire ce_set = lin_any && ch_csum && !checksum_disable &&
                (LIN_CHAR_DATA != ~sum_reg);

  wire snre_set = lin_any && (node_action == usart_lin_pkg::NODE_ACTION_RECEIVE) &&
                  LIN_FRAME_TIMEOUT && !LIN_FRAME_VALID;

  // |new - init| * 100 > init * 15
  wire [16:0] diff = (LIN_BAUD_NEW >= LIN_BAUD_INIT) ?
    {1'b0, LIN_BAUD_NEW - LIN_BAUD_INIT} :
    {1'b0, LIN_BAUD_INIT - LIN_BAUD_NEW};
  wire [23:0] diff_scaled = {7'h00, diff} * 24'd100;
  wire [23:0] tol_scaled = {8'h00, LIN_BAUD_INIT} *
                           24'(usart_lin_pkg::TOL_PCT);
  wire ste_set = lin_slave && LIN_SYNC_DONE &&
                 (diff_scaled > tol_scaled);

  // sticky flags, set wins over status reset
  logic [6:0] flags;
  wire [6:0] flag_set = {ste_set, snre_set, ce_set, ipe_set, isfe_set,
                         bit_mismatch, brk_start || brk_end};
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_flag
      sticky_flag u_flag (
        .clk   (CLK),
        .rst_n (rst_n),
        .set   (flag_set[gi]),
        .clr   (status_reset_cmd),
        .flag  (flags[gi])
      );
    end
  endgenerate

  logic [31:0] status;
  always_comb begin
    status = usart_lin_pkg::RESET_ZERO;
    status[usart_lin_pkg::ST_RX_BREAK_FLAG] = flags[0];
    status[usart_lin_pkg::ST_LIN_BIT_ERROR_FLAG] = flags[1];
    status[usart_lin_pkg::ST_ISFE]  = flags[2];
    status[usart_lin_pkg::ST_IPE]   = flags[3];
    status[usart_lin_pkg::ST_CE]    = flags[4];
    status[usart_lin_pkg::ST_SNRE]  = flags[5];
    status[usart_lin_pkg::ST_STE]   = flags[6];
    status[0] = frame_err;
  end

  wire [7:0] raddr = HADDR[7:0];
  wire [31:0] rdata_next =
    (raddr == usart_lin_pkg::OFF_MODE)   ? mode_reg :
    (raddr == usart_lin_pkg::OFF_IMR)    ? ier_reg :
    (raddr == usart_lin_pkg::OFF_STATUS) ? status :
    (raddr == usart_lin_pkg::OFF_LINCFG) ? lincfg_reg :
    usart_lin_pkg::RESET_ZERO;

  // rts high asks the remote to stop while the receiver is full
  wire rts_next = handshake ? RX_FIFO_FULL : 1'b0;
  wire txen_next = !handshake || !CTS;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA     <= usart_lin_pkg::RESET_ZERO;
      RTS        <= 1'b0;
      TX_ENABLE  <= 1'b1;
      TX_ABORT   <= 1'b0;
      USART_MODE <= 4'h0;
      IRQ_ENABLE <= usart_lin_pkg::RESET_ZERO;
    end else begin
      if (rd_phase) HRDATA <= rdata_next;
      RTS        <= rts_next;
      TX_ENABLE  <= txen_next;
      TX_ABORT   <= abort_now;
      USART_MODE <= mode;
      IRQ_ENABLE <= ier_reg;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end
endmodule

// *** sim/usart_lin_errors_asserts.sv ***
// checker: port relations of the break/handshake/lin block
`timescale 1ns/100ps
module usart_lin_errors_asserts (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic        CTS,
  input wire logic        RX_FIFO_FULL,
  input wire logic        TX_BYTE_END,
  input wire logic        RTS,
  input wire logic        TX_ENABLE,
  input wire logic        TX_ABORT,
  input wire logic [3:0]  USART_MODE,
  input wire logic [31:0] IRQ_ENABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire hs  = USART_MODE == usart_lin_pkg::MODE_HANDSHAKE;
  wire spi = USART_MODE == usart_lin_pkg::MODE_SPI_M ||
             USART_MODE == usart_lin_pkg::MODE_SPI_S;
  // two samples of the mode: outputs lag a mode write by one cycle
  a_rts_idle: assert property ((!hs)[*2] |-> !RTS)
    else $error("rts raised outside handshake mode");
  a_txen_idle: assert property ((!hs)[*2] |-> TX_ENABLE)
    else $error("transmitter gated outside handshake mode");
  a_rts_follow: assert property (hs[*2] |-> RTS == $past(RX_FIFO_FULL))
    else $error("rts does not follow receiver full");
  a_cts_gate: assert property (hs[*2] |-> TX_ENABLE == !$past(CTS))
    else $error("transmit enable does not follow cts");
  a_abort_border: assert property (TX_ABORT |-> $past(TX_BYTE_END))
    else $error("abort away from a byte border");
  a_en_spi_only: assert property ($changed(IRQ_ENABLE) |-> $past(spi))
    else $error("enables changed outside spi mode");
  a_en_no_clear: assert property (($past(IRQ_ENABLE) & ~IRQ_ENABLE) == 0)
    else $error("an enable bit was cleared");
  a_en_bits_only: assert property (
    (IRQ_ENABLE & 32'hFFF7_F9DC) == 0)
    else $error("enable set outside the defined bits");
  c_stall: cover property (hs && CTS ##1 !TX_ENABLE);
  c_abort: cover property (TX_ABORT);
  c_enable: cover property ($changed(IRQ_ENABLE));
endmodule

bind usart_lin_errors usart_lin_errors_asserts u_chk (.CLK, .RESETN, .CTS,
  .RX_FIFO_FULL, .TX_BYTE_END, .RTS, .TX_ENABLE, .TX_ABORT, .USART_MODE,
  .IRQ_ENABLE);

// *** sim/remote_serial_model.sv ***
// partner: remote serial device on the rts/cts and receive lines
`timescale 1ns/100ps
module remote_serial_model (
  input  wire logic clk,
  input  wire logic rts,
  input  wire logic stall,
  input  wire logic line,
  output logic      cts,
  output logic      rxd
);
  logic cts_reg = 1'b0;
  logic rxd_reg = 1'b1;
  // remote holds its line at mark while asked to stop
  always @(posedge clk) begin
    cts_reg <= stall;
    rxd_reg <= rts ? 1'b1 : line;
  end
  assign cts = cts_reg;
  assign rxd = rxd_reg;
endmodule

// *** sim/usart_lin_errors_tb.sv ***
// testbench: register bus, break, handshake, lin flags, spi enables
`timescale 1ns/100ps
module usart_lin_errors_tb;
  localparam logic [7:0]  ctl = usart_lin_pkg::OFF_CTRL;
  localparam logic [7:0]  mdr = usart_lin_pkg::OFF_MODE;
  localparam logic [7:0]  en_set = usart_lin_pkg::OFF_IER;
  localparam logic [7:0]  en_rd = usart_lin_pkg::OFF_IMR;
  localparam logic [7:0]  sts = usart_lin_pkg::OFF_STATUS;
  localparam logic [7:0]  lcfg = usart_lin_pkg::OFF_LINCFG;
  localparam logic [31:0] clr = 32'h0000_0100;
  logic        CLK = 1'b0, RESETN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [1:0]  HTRANS = 2'h0, LIN_CHAR_KIND = 2'h0;
  logic [31:0] HADDR = 32'h0000_0000, HWDATA = 32'h0000_0000;
  logic [7:0]  pl = 8'h00, LIN_CHAR_DATA = 8'h00;
  logic [15:0] LIN_BAUD_NEW = 16'h0000;
  logic        RX_FIFO_FULL = 1'b0, TX_LINE = 1'b1, TX_ACTIVE = 1'b0;
  logic        stall = 1'b0, line = 1'b1, frame_ok = 1'b0;
  logic [8:0]  rx_bits = 9'h000;
  wire  [31:0] HRDATA, IRQ_ENABLE;
  wire  [3:0]  USART_MODE;
  wire         HREADYOUT, HRESP, RTS, TX_ENABLE, TX_ABORT, CTS, RXD;
  int          fails = 0, total_checks = 0;

  always #4 CLK = ~CLK;

  usart_lin_errors u_dut (.CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .SAMPLE_TICK(pl[0]), .RXD, .RX_CHAR_DONE(pl[1]), .RX_CHAR_BITS(rx_bits),
    .RX_FIFO_FULL, .TX_BIT_TICK(pl[2]), .TX_LINE, .TX_BYTE_END(pl[3]),
    .TX_ACTIVE, .CTS, .LIN_CHAR_KIND, .LIN_CHAR_VALID(pl[4]),
    .LIN_CHAR_DATA, .LIN_FRAME_START(pl[5]), .LIN_FRAME_VALID(frame_ok),
    .LIN_FRAME_TIMEOUT(pl[6]), .LIN_SYNC_DONE(pl[7]),
    .LIN_BAUD_INIT(16'h0064), .LIN_BAUD_NEW, .RTS, .TX_ENABLE, .TX_ABORT,
    .USART_MODE, .IRQ_ENABLE);
  remote_serial_model u_remote (.clk(CLK), .rts(RTS), .stall, .line,
    .cts(CTS), .rxd(RXD));

  task automatic test_done();
    if (fails == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // single transfer; waits on hready, never assumes a latency
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge CLK);
    HSEL <= 1'b1;
    HADDR <= {24'h00_0000, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0000_0000, r);
    chk(n, e, r);
    chk("hresp", 32'h0000_0000, HRESP);
  endtask
  task automatic pulse(input int i);
    @(posedge CLK);
    pl <= 8'h01 << i;
    @(posedge CLK);
    pl <= 8'h00;
  endtask
  task automatic ch(input logic [1:0] k, input logic [7:0] d);
    LIN_CHAR_KIND <= k;
    LIN_CHAR_DATA <= d;
    pulse(4);
  endtask

  task automatic t_enables();
    rd("mask after reset", en_rd, 32'h0000_0000);
    wr(en_set, 32'hFFFF_FFFF);
    rd("mask outside spi", en_rd, 32'h0000_0000);
    wr(mdr, 32'h0000_000E);
    wr(en_set, 32'h0008_0000);
    rd("slave select enable", en_rd, 32'h0008_0000);
    wr(en_set, 32'h0000_0000);
    rd("zero write keeps", en_rd, 32'h0008_0000);
    wr(mdr, 32'h0000_000F);
    wr(en_set, 32'hFFFF_FFFF);
    rd("all enables", en_rd, 32'h0008_0623);
    chk("enable output", 32'h0008_0623, IRQ_ENABLE);
    rd("write only read", en_set, 32'h0000_0000);
    rd("unmapped read", 8'h40, 32'h0000_0000);
  endtask
  // sync mode ends a break on one high sample, async needs two
  task automatic t_break(input logic sync);
    wr(mdr, sync ? 32'h0000_0100 : 32'h0000_0000);
    rx_bits <= 9'h100;
    pulse(1);
    rd("char not break", sts, 32'h0000_0000);
    rx_bits <= 9'h000;
    line <= 1'b0;
    pulse(1);
    rd("break flag", sts, 32'h0000_0004);
    wr(ctl, clr);
    rd("break cleared", sts, 32'h0000_0000);
    line <= 1'b1;
    repeat (2) @(posedge CLK);
    pulse(0);
    rd("one high sample", sts, {29'h0000_0000, sync, 2'h0});
    if (!sync) begin
      pulse(0);
      rd("end of break", sts, 32'h0000_0004);
    end
    wr(ctl, clr);
  endtask
  task automatic t_handshake();
    wr(mdr, 32'h0000_0002);
    stall <= 1'b1;
    RX_FIFO_FULL <= 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk("tx enable", 1'h0, TX_ENABLE);
    chk("rts", 1'h1, RTS);
    @(posedge CLK);
    stall <= 1'b0;
    RX_FIFO_FULL <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk("tx enable free", 1'h1, TX_ENABLE);
    chk("rts free", 1'h0, RTS);
  endtask
  task automatic t_bit_error();
    wr(mdr, 32'h0000_000A);
    TX_ACTIVE <= 1'b1;
    pulse(2);
    pulse(3);
    #1;
    chk("abort without error", 1'h0, TX_ABORT);
    @(posedge CLK);
    TX_LINE <= 1'b0;
    pulse(2);
    #1;
    chk("abort mid byte", 1'h0, TX_ABORT);
    pulse(3);
    #1;
    chk("abort at border", 1'h1, TX_ABORT);
    rd("bit error", sts, 32'h0200_0000);
    TX_ACTIVE <= 1'b0;
    TX_LINE <= 1'b1;
    wr(ctl, clr);
  endtask
  // bad frame: wrong synch, id parity, checksum, no answer, 16% off
  // good frame: id 0x80 has correct parity, 0xfe is the data checksum
  task automatic t_lin(input logic [31:0] cfg, input logic bad,
                       input logic [31:0] e);
    wr(mdr, 32'h0000_000B);
    wr(lcfg, cfg);
    chk("mode out", 32'h0000_000B, USART_MODE);
    frame_ok <= !bad;
    ch(2'h0, bad ? 8'h54 : 8'h55);
    ch(2'h1, bad ? 8'h00 : 8'h80);
    pulse(5);
    ch(2'h3, 8'h01);
    ch(2'h2, bad ? 8'h00 : 8'hFE);
    pulse(6);
    LIN_BAUD_NEW <= bad ? 16'h0074 : 16'h0073;
    pulse(7);
    rd("lin flags", sts, e);
    rd("lin flags kept", sts, e);
    wr(ctl, clr);
    rd("lin flags cleared", sts, 32'h0000_0000);
  endtask

  initial begin
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    t_enables();
    t_break(1'b0);
    t_break(1'b1);
    t_handshake();
    t_bit_error();
    t_lin(32'h0000_0001, 1'b0, 32'h0000_0000);
    t_lin(32'h0000_000C, 1'b1, 32'h4400_0000);
    t_lin(32'h0000_000E, 1'b1, 32'h4400_0000);
    t_lin(32'h0000_0001, 1'b1, 32'h7C00_0000);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    test_done();
  end
endmodule
